//--- logic/cft_defines.vh
// constants for the contactless frame tuning block
//
// Overview of operation
// RULE_01: parity_off set: no parity appended on transmit, none checked on receive.
// RULE_02: parity_off set: the would-be parity bit is received as ordinary data.
// RULE_03: highpass_override clear: corner follows receive mode; set: corner field applies.
// RULE_04: corner field 00/01/10/11 selects 106/212/424/848 kHz high-pass corner.
// RULE_05: wide_recovery_loop set widens the receive clock recovery loop bandwidth.
// RULE_06: miller_filter_fast set puts Miller filter in fast mode; only for short pulses.
// RULE_07: signal_out_delay set delays signal_out_pin output by 128 carrier cycles.
// RULE_08: software enables signal_out_delay only with signal_out_source 1110b or 1111b.
// RULE_09: rx_start_mark_required set: streams lacking a start mark are discarded.
// RULE_10: start mark optional when clear; it never reaches the FIFO.
// RULE_11: rx_end_mark_required set: stream ending without end mark flags protocol error.
// RULE_12: end mark optional when clear; it never reaches the FIFO.
// RULE_13: trim clear: marks take maximum length if length select set, else minimum.
// RULE_14: select and trim set: start low 11etu-8, high 2etu+8, end low 11etu-8. Here trim is never set: rx_tuning bit 7 and framing bit 5 are masked to zero.
// RULE_15: software never programs length select 0 with trim 1.
// RULE_16: tx_start_mark_suppress set: frames are sent without a start mark.
// RULE_17: tx_end_mark_suppress set: frames are sent without an end mark.
// RULE_18: extra guard field gives 0, 1, 2 or 3 guard bits after each character.
// RULE_19: receiver tuning register resets to 00h.
// RULE_20: framing register resets to all zeros.
// RULE_21: reserved bits read as zero and ignore writes.
`ifndef CFT_DEFINES_VH
`define CFT_DEFINES_VH

// register indices, byte address is four times the index
`define CFT_IDX_RX_TUNING 6'h1D
`define CFT_IDX_FRAMING 6'h1E
`define CFT_IDX_STATUS 6'h2F
`define CFT_RX_TUNING_RESET 8'h00
`define CFT_FRAMING_RESET 8'h00
`define CFT_RX_TUNING_MASK 8'h7F
`define CFT_FRAMING_MASK 8'hDF
`define CFT_STATUS_W1C_MASK 8'h0C

// receiver tuning fields
`define CFT_BIT_MILLER_FAST 6
`define CFT_BIT_SIGNAL_OUT_PIN_DELAY 5
`define CFT_BIT_PARITY_OFF 4
`define CFT_BIT_WIDE_LOOP 3
`define CFT_BIT_HP_OVERRIDE 2
`define CFT_HP_CORNER_LSB 0

// framing fields
`define CFT_BIT_RX_SOF_REQ 7
`define CFT_BIT_RX_EOF_REQ 6
`define CFT_BIT_MARK_LEN_SEL 4
`define CFT_BIT_TX_SOF_SUPP 3
`define CFT_BIT_TX_EOF_SUPP 2
`define CFT_EGT_LSB 0

// timing in carrier cycles and etu
`define CFT_ETU_FC 128
`define CFT_MARK_TRIM_FC 8
`define CFT_SOF_LOW_MIN_ETU 10
`define CFT_SOF_LOW_MAX_ETU 11
`define CFT_SOF_HIGH_MIN_ETU 2
`define CFT_SOF_HIGH_MAX_ETU 3
`define CFT_EOF_LOW_MIN_ETU 10
`define CFT_EOF_LOW_MAX_ETU 11
`define CFT_SIGNAL_OUT_PIN_DELAY_FC 128

`endif

//--- logic/cft_frame_tuning.v
// contactless frame tuning: registers, type B framer, receive deframer, signal-out delay
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cft_defines.vh"

module cft_frame_tuning #(
	parameter ETU_FC = `CFT_ETU_FC,
	parameter DELAY_FC = `CFT_SIGNAL_OUT_PIN_DELAY_FC
) (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// carrier timing and receive mode
	input wire fc_tick,
	input wire [1:0] rx_speed_sel,
	// receive bit stream from demodulator
	input wire rx_start,
	input wire rx_sof_present,
	input wire rx_bit_valid,
	input wire rx_bit,
	input wire rx_stop,
	input wire rx_eof_present,
	// receive fifo write side and events
	output reg fifo_wr,
	output reg [7:0] fifo_data,
	output reg rx_parity_err,
	output reg rx_protocol_err,
	// transmit byte source
	input wire tx_start,
	input wire [7:0] tx_data,
	input wire tx_data_valid,
	input wire tx_last,
	output wire tx_data_ready,
	output reg tx_mod,
	output wire tx_busy,
	// signal pins
	input wire signal_in_pin,
	output reg signal_out_pin,
	// analog front end controls
	output wire [1:0] hp_corner,
	output wire wide_recovery_loop,
	output wire miller_filter_fast
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_SOFL = 6'h02;
	localparam [5:0] ST_SOFH = 6'h04;
	localparam [5:0] ST_LOAD = 6'h08;
	localparam [5:0] ST_CHAR = 6'h10;
	localparam [5:0] ST_EOFL = 6'h20;
	localparam [1:0] MK_SOFL = 2'h0;
	localparam [1:0] MK_SOFH = 2'h1;
	localparam [1:0] MK_EOFL = 2'h2;
	localparam [11:0] ETU = ETU_FC[11:0];

	////////////////////////////////////////////////////////////////////////////////
	// registers and apb

	reg [7:0] rx_tuning;
	reg [7:0] framing;
	reg parity_err_seen;
	reg protocol_err_seen;
	reg rx_active;
	reg rx_discard;
	reg [5:0] tx_state;

	wire wr_en = psel & penable & pwrite;
	wire [5:0] idx = paddr[7:2];
	wire hit_tuning = (idx == `CFT_IDX_RX_TUNING);
	wire hit_framing = (idx == `CFT_IDX_FRAMING);
	wire hit_status = (idx == `CFT_IDX_STATUS);
	wire aligned = (paddr[1:0] == 2'h0);
	wire mapped = aligned & (hit_tuning | hit_framing | hit_status);

	// no wait states: every access completes at its first access edge
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	wire parity_off = rx_tuning[`CFT_BIT_PARITY_OFF];
	wire signal_out_pin_delay = rx_tuning[`CFT_BIT_SIGNAL_OUT_PIN_DELAY];
	wire rx_sof_req = framing[`CFT_BIT_RX_SOF_REQ];
	wire rx_eof_req = framing[`CFT_BIT_RX_EOF_REQ];
	wire mark_len_sel = framing[`CFT_BIT_MARK_LEN_SEL];
	wire mark_trim = rx_tuning[7] | framing[5];
	wire tx_sof_supp = framing[`CFT_BIT_TX_SOF_SUPP];
	wire tx_eof_supp = framing[`CFT_BIT_TX_EOF_SUPP];
	wire [1:0] egt_len = framing[`CFT_EGT_LSB+1:`CFT_EGT_LSB];

	// trim has no register bit of its own here; mark_trim above ORs two masked bits
	wire [7:0] status = {4'h0, protocol_err_seen, parity_err_seen, rx_active, ~tx_state[0]};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_tuning <= `CFT_RX_TUNING_RESET; // see RULE_19
			framing <= `CFT_FRAMING_RESET; // see RULE_20
		end else if (wr_en & hit_tuning & aligned) begin
			rx_tuning <= pwdata[7:0] & `CFT_RX_TUNING_MASK; // see RULE_21
		end else if (wr_en & hit_framing & aligned) begin
			framing <= pwdata[7:0] & `CFT_FRAMING_MASK; // see RULE_21
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (psel & ~pwrite & mapped) begin
			case (1'b1)
				hit_tuning: prdata = {24'h00_0000, rx_tuning};
				hit_framing: prdata = {24'h00_0000, framing};
				default: prdata = {24'h00_0000, status};
			endcase
		end
	end

	// sticky error flags, write one to clear, a new event wins
	wire clr_err = wr_en & hit_status & aligned;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_err_seen <= 1'b0;
			protocol_err_seen <= 1'b0;
		end else begin
			if (rx_parity_err)
				parity_err_seen <= 1'b1;
			else if (clr_err & pwdata[2])
				parity_err_seen <= 1'b0;
			if (rx_protocol_err)
				protocol_err_seen <= 1'b1;
			else if (clr_err & pwdata[3])
				protocol_err_seen <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog controls

	assign hp_corner = rx_tuning[`CFT_BIT_HP_OVERRIDE] ?
		rx_tuning[`CFT_HP_CORNER_LSB+1:`CFT_HP_CORNER_LSB] : rx_speed_sel; // see RULE_03, RULE_04
	assign wide_recovery_loop = rx_tuning[`CFT_BIT_WIDE_LOOP]; // see RULE_05
	assign miller_filter_fast = rx_tuning[`CFT_BIT_MILLER_FAST]; // see RULE_06

	////////////////////////////////////////////////////////////////////////////////
	// receive deframer

	reg [7:0] rx_shift;
	reg [3:0] rx_cnt;

	// bits count only inside an accepted stream
	wire rx_take = rx_active & ~rx_discard & rx_bit_valid;
	wire [7:0] rx_next_shift = {rx_bit, rx_shift[7:1]};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_active <= 1'b0;
			rx_discard <= 1'b0;
			rx_shift <= 8'h00;
			rx_cnt <= 4'h0;
			fifo_wr <= 1'b0;
			fifo_data <= 8'h00;
			rx_parity_err <= 1'b0;
			rx_protocol_err <= 1'b0;
		end else begin
			fifo_wr <= 1'b0;
			rx_parity_err <= 1'b0;
			rx_protocol_err <= 1'b0;
			if (rx_start) begin
				// start mark is a marker only, never data
				rx_active <= 1'b1;
				rx_discard <= rx_sof_req & ~rx_sof_present; // see RULE_09, RULE_10
				rx_cnt <= 4'h0;
			end else if (rx_stop) begin
				rx_active <= 1'b0;
				rx_discard <= 1'b0;
				if (rx_active & ~rx_discard & rx_eof_req & ~rx_eof_present)
					rx_protocol_err <= 1'b1; // see RULE_11, RULE_12
			end else if (rx_take) begin
				if (parity_off) begin
					// every bit is data, parity position included
					rx_shift <= rx_next_shift; // see RULE_02
					if (rx_cnt == 4'h7) begin
						rx_cnt <= 4'h0;
						fifo_wr <= 1'b1;
						fifo_data <= rx_next_shift;
					end else begin
						rx_cnt <= rx_cnt + 4'h1;
					end
				end else if (rx_cnt == 4'h8) begin
					rx_cnt <= 4'h0;
					fifo_wr <= 1'b1;
					fifo_data <= rx_shift;
					// odd parity: data and parity bit hold an odd count of ones
					rx_parity_err <= ~(^{rx_shift, rx_bit}); // see RULE_01
				end else begin
					rx_shift <= rx_next_shift;
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit framer

	// mark length in carrier cycles, cut to the counter width
	function [11:0] mark_len;
		input [1:0] kind;
		input sel;
		input trim;
		reg [31:0] full;
		begin
			if (trim) begin
				if (kind == MK_SOFH)
					full = `CFT_SOF_HIGH_MIN_ETU * ETU + `CFT_MARK_TRIM_FC;
				else
					full = `CFT_SOF_LOW_MAX_ETU * ETU - `CFT_MARK_TRIM_FC;
			end else if (kind == MK_SOFH) begin
				full = (sel ? `CFT_SOF_HIGH_MAX_ETU : `CFT_SOF_HIGH_MIN_ETU) * ETU;
			end else if (kind == MK_SOFL) begin
				full = (sel ? `CFT_SOF_LOW_MAX_ETU : `CFT_SOF_LOW_MIN_ETU) * ETU;
			end else begin
				full = (sel ? `CFT_EOF_LOW_MAX_ETU : `CFT_EOF_LOW_MIN_ETU) * ETU;
			end
			mark_len = full[11:0];
		end
	endfunction

	reg [11:0] tx_cnt;
	reg [10:0] tx_shift;
	reg [3:0] tx_bits;
	reg tx_was_last;
	reg [5:0] next_tx_state;

	// a phase ends on the carrier tick that finds the counter empty
	wire phase_done = fc_tick & (tx_cnt == 12'h000);
	assign tx_data_ready = tx_state[3];
	assign tx_busy = ~tx_state[0];

	always @* begin
		next_tx_state = tx_state;
		case (tx_state)
			ST_IDLE:
				if (tx_start)
					next_tx_state = tx_sof_supp ? ST_LOAD : ST_SOFL; // see RULE_16
			ST_SOFL:
				if (phase_done)
					next_tx_state = ST_SOFH;
			ST_SOFH:
				if (phase_done)
					next_tx_state = ST_LOAD;
			ST_LOAD:
				if (tx_data_valid)
					next_tx_state = ST_CHAR;
			ST_CHAR:
				if (phase_done & (tx_bits == 4'h0)) begin
					if (!tx_was_last)
						next_tx_state = ST_LOAD;
					else if (tx_eof_supp)
						next_tx_state = ST_IDLE; // see RULE_17
					else
						next_tx_state = ST_EOFL;
				end
			ST_EOFL:
				if (phase_done)
					next_tx_state = ST_IDLE;
			default:
				next_tx_state = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= ST_IDLE;
			tx_cnt <= 12'h000;
			tx_shift <= 11'h7FF;
			tx_bits <= 4'h0;
			tx_was_last <= 1'b0;
			tx_mod <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			if (fc_tick & (tx_cnt != 12'h000))
				tx_cnt <= tx_cnt - 12'h001;
			case (tx_state)
				// idle line is high; marks and start bits pull it low
				ST_IDLE: begin
					tx_mod <= 1'b1;
					if (tx_start & ~tx_sof_supp) begin
						tx_mod <= 1'b0;
						tx_cnt <= mark_len(MK_SOFL, mark_len_sel, mark_trim) - 12'h001; // see RULE_13, RULE_14
					end
				end
				ST_SOFL:
					if (phase_done) begin
						tx_mod <= 1'b1;
						tx_cnt <= mark_len(MK_SOFH, mark_len_sel, mark_trim) - 12'h001; // see RULE_14
					end
				ST_SOFH:
					if (phase_done)
						tx_mod <= 1'b1;
				ST_LOAD:
					if (tx_data_valid) begin
						// start bit, data lsb first, optional parity, stop, guard bits
						tx_mod <= 1'b0;
						tx_cnt <= ETU - 12'h001;
						tx_was_last <= tx_last;
						if (parity_off)
							tx_shift <= {2'h3, tx_data, 1'b0}; // see RULE_01
						else
							tx_shift <= {1'b1, ~(^tx_data), tx_data, 1'b0};
						tx_bits <= (parity_off ? 4'h9 : 4'hA) + {2'h0, egt_len}; // see RULE_18
					end
				ST_CHAR:
					if (phase_done) begin
						if (tx_bits != 4'h0) begin
							tx_shift <= {1'b1, tx_shift[10:1]};
							tx_mod <= tx_shift[1];
							tx_bits <= tx_bits - 4'h1;
							tx_cnt <= ETU - 12'h001;
						end else if (tx_was_last & ~tx_eof_supp) begin
							tx_mod <= 1'b0;
							tx_cnt <= mark_len(MK_EOFL, mark_len_sel, mark_trim) - 12'h001; // see RULE_13
						end else begin
							tx_mod <= 1'b1;
						end
					end
				ST_EOFL:
					if (phase_done)
						tx_mod <= 1'b1;
				default:
					tx_mod <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// signal-out delay line

	reg sig_s1;
	reg sig_s2;
	reg sig_s3;
	reg sig_level;
	reg [DELAY_FC-1:0] sig_line;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_s1 <= 1'b0;
			sig_s2 <= 1'b0;
			sig_s3 <= 1'b0;
			sig_level <= 1'b0;
			sig_line <= {DELAY_FC{1'b0}};
			signal_out_pin <= 1'b0;
		end else begin
			sig_s1 <= signal_in_pin;
			sig_s2 <= sig_s1;
			sig_s3 <= sig_s2;
			// a level counts once stages two and three agree
			if (sig_s2 == sig_s3)
				sig_level <= sig_s3;
			// delay line moves on carrier ticks
			if (fc_tick)
				sig_line <= {sig_line[DELAY_FC-2:0], sig_level};
			signal_out_pin <= signal_out_pin_delay ? sig_line[DELAY_FC-1] : sig_level; // see RULE_07
		end
	end

endmodule // cft_frame_tuning
`default_nettype wire

//--- dv/cft_frame_tuning_checker.sv
// assertions on the frame tuning block ports
`timescale 1ns/100ps
`default_nettype none
module cft_frame_tuning_checker #(
	parameter ETU_FC = 128,
	parameter DELAY_FC = 128
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	// framing and front end
	input wire [1:0] rx_speed_sel,
	input wire rx_stop,
	input wire rx_parity_err,
	input wire rx_protocol_err,
	input wire tx_start,
	input wire tx_busy,
	input wire tx_mod,
	input wire [1:0] hp_corner,
	input wire wide_recovery_loop,
	input wire miller_filter_fast
);
	logic [7:0] tune;
	logic [7:0] frm;
	wire wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune <= 8'h00;
			frm <= 8'h00;
		end else if (wr && paddr == 8'h74) begin
			tune <= pwdata[7:0] & 8'h7F;
		end else if (wr && paddr == 8'h78) begin
			frm <= pwdata[7:0] & 8'hDF;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence tx_go;
		tx_start && !tx_busy;
	endsequence
	sequence rd_at(logic [7:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	corner_auto_a: assert property (!tune[2] |-> hp_corner == rx_speed_sel)
		else $error("auto corner wrong");
	corner_manual_a: assert property (tune[2] |-> hp_corner == tune[1:0])
		else $error("manual corner wrong");
	wide_loop_a: assert property (wide_recovery_loop == tune[3])
		else $error("recovery loop wrong");
	miller_fast_a: assert property (miller_filter_fast == tune[6])
		else $error("miller filter wrong");
	tune_read_a: assert property (rd_at(8'h74) |-> prdata == {24'h0, tune})
		else $error("tuning readback wrong");
	frame_read_a: assert property (rd_at(8'h78) |-> prdata == {24'h0, frm})
		else $error("framing readback wrong");
	parity_quiet_a: assert property (tune[4] |-> !rx_parity_err)
		else $error("parity checked while off");
	sof_low_a: assert property (tx_go ##0 !frm[3] |=> !tx_mod [*8])
		else $error("start mark missing");
	sof_skip_a: assert property (tx_go ##0 frm[3] |=> tx_mod)
		else $error("start mark sent");
	eof_free_a: assert property (rx_stop && !frm[6] |=> !rx_protocol_err)
		else $error("end mark demanded");
endmodule // cft_frame_tuning_checker
bind cft_frame_tuning cft_frame_tuning_checker #(.ETU_FC(ETU_FC), .DELAY_FC(DELAY_FC)) u_chk (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .rx_speed_sel(rx_speed_sel),
	.rx_stop(rx_stop), .rx_parity_err(rx_parity_err), .rx_protocol_err(rx_protocol_err),
	.tx_start(tx_start), .tx_busy(tx_busy), .tx_mod(tx_mod), .hp_corner(hp_corner),
	.wide_recovery_loop(wide_recovery_loop), .miller_filter_fast(miller_filter_fast));
`default_nettype wire

//--- dv/cft_card_model.sv
// far side card: sends receive streams, times the transmit line
`timescale 1ns/100ps
`default_nettype none
module cft_card_model (
	// clock and line from the block
	input wire pclk,
	input wire tx_mod,
	// stream towards the block
	output logic rx_start,
	output logic rx_sof_present,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_stop,
	output logic rx_eof_present
);
	int run;
	int hrun;
	int runs[$];
	int highs[$];
	initial begin
		{rx_start, rx_sof_present, rx_bit_valid, rx_bit, rx_stop, rx_eof_present} = 6'h00;
		run = 0;
		hrun = 0;
	end
	// low and high run lengths of the modulated line
	always @(posedge pclk) begin
		if (tx_mod === 1'b0) begin
			run++;
			if (hrun > 0)
				highs.push_back(hrun);
			hrun = 0;
		end else begin
			hrun++;
			if (run > 0)
				runs.push_back(run);
			run = 0;
		end
	end
	task automatic stream(input logic sof, input logic eof, input int n, input logic [8:0] b);
		@(posedge pclk);
		rx_start <= 1'b1;
		rx_sof_present <= sof;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rx_start <= 1'b0;
			rx_bit_valid <= 1'b1;
			rx_bit <= b[i];
		end
		@(posedge pclk);
		rx_bit_valid <= 1'b0;
		rx_bit <= ~b[n-1];
		rx_stop <= 1'b1;
		rx_eof_present <= eof;
		@(posedge pclk);
		rx_stop <= 1'b0;
		rx_eof_present <= ~eof;
		rx_sof_present <= ~sof;
		repeat (3) @(posedge pclk);
	endtask
endmodule // cft_card_model
`default_nettype wire

//--- dv/cft_frame_tuning_bench.sv
// self-checking bench for the frame tuning block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module cft_frame_tuning_bench;
	localparam int ETU = 4;
	logic pclk, presetn, psel, penable, pwrite, fc_tick, tx_start, tx_data_valid, signal_in_pin;
	logic [7:0] paddr, tx_data, b, f;
	logic [31:0] pwdata, rd;
	logic [31:0] seed = 32'h9979CD96;
	logic pin_force, pin_lvl;
	wire sig_out;
	logic [1:0] rx_speed_sel;
	logic err, pe;
	wire [31:0] prdata;
	wire [7:0] fifo_data;
	wire [1:0] hp_corner;
	wire pready, pslverr, fifo_wr, rx_parity_err, rx_protocol_err, tx_data_ready, tx_mod, tx_busy;
	wire rx_start, rx_sof_present, rx_bit_valid, rx_bit, rx_stop, rx_eof_present;
	int mismatches, samples_checked, pcnt, len;
	logic [8:0] got[$];
	cft_frame_tuning #(.ETU_FC(ETU), .DELAY_FC(4)) u_cft_frame_tuning (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fc_tick(fc_tick), .rx_speed_sel(rx_speed_sel), .rx_start(rx_start),
		.rx_sof_present(rx_sof_present), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rx_stop(rx_stop), .rx_eof_present(rx_eof_present), .fifo_wr(fifo_wr),
		.fifo_data(fifo_data), .rx_parity_err(rx_parity_err), .rx_protocol_err(rx_protocol_err),
		.tx_start(tx_start), .tx_data(tx_data), .tx_data_valid(tx_data_valid), .tx_last(1'b1),
		.tx_data_ready(tx_data_ready), .tx_mod(tx_mod), .tx_busy(tx_busy),
		.signal_in_pin(signal_in_pin), .signal_out_pin(sig_out), .hp_corner(hp_corner),
		.wide_recovery_loop(), .miller_filter_fast());
	cft_card_model u_card (.pclk(pclk), .tx_mod(tx_mod), .rx_start(rx_start),
		.rx_sof_present(rx_sof_present), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rx_stop(rx_stop), .rx_eof_present(rx_eof_present));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		seed <= lfsr(seed);
		rx_speed_sel <= seed[1:0];
		signal_in_pin <= pin_force ? pin_lvl : seed[2];
	end
	always @(negedge pclk) begin
		if (fifo_wr === 1'b1) got.push_back({rx_parity_err, fifo_data});
		if (rx_protocol_err === 1'b1) pcnt++;
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_tx(input logic busy, input logic v);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (((busy ? tx_busy : tx_data_ready) !== v) && n < 500);
		if ((busy ? tx_busy : tx_data_ready) !== v) mismatches++;
	endtask
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		stop_test;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tx_start, tx_data, tx_data_valid} = '0;
		{fc_tick, presetn, pin_force, pin_lvl} = 4'h8;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h74, 0);
		`CHK("tuning reset", 32'h0, rd)
		apb(0, 8'h78, 0);
		`CHK("framing reset", 32'h0, rd)
		apb(1, 8'h74, '1);
		apb(0, 8'h74, 0);
		`CHK("tuning reserved", 32'h7F, rd)
		apb(1, 8'h78, '1);
		apb(0, 8'h78, 0);
		`CHK("framing reserved", 32'hDF, rd)
		apb(0, 8'h40, 0);
		`CHK("unmapped error", 1'b1, err)
		for (int i = 0; i < 6; i++) begin
			f = (i == 4) ? 8'h80 : (i == 5) ? 8'h40 : 8'h00;
			apb(1, 8'h78, f);
			apb(1, 8'h74, {3'b010, i[0], 2'b11, i[1:0]});
			b = seed[7:0];
			pe = i[1];
			got.delete();
			pcnt = 0;
			u_card.stream(i != 4, i != 5, 9, {(~^b) ^ pe, b});
			u_card.stream(i == 4, 1'b1, 9, {~^b, b});
			`CHK("rx count", (i == 4) ? 1 : 2, got.size())
			`CHK("rx byte", {pe & ~i[0], b}, got[0])
			`CHK("protocol error", (i == 5) ? 1 : 0, pcnt)
		end
		apb(1, 8'h74, 0);
		for (int i = 0; i < 4; i++) begin
			f = {3'b000, i[0], i[1], i[1] & ~i[0], i[1:0]};
			apb(1, 8'h78, f);
			len = (f[4] ? 11 : 10) * ETU;
			u_card.runs.delete();
			u_card.highs.delete();
			@(posedge pclk);
			tx_start <= 1'b1;
			@(posedge pclk);
			{tx_start, tx_data, tx_data_valid} <= {1'b0, 8'hFF, 1'b1};
			wait_tx(1'b0, 1'b1);
			tx_data_valid <= 1'b0;
			wait_tx(1'b1, 1'b0);
			repeat (2) @(posedge pclk);
			`CHK("mark runs", 3 - f[3] - f[2], u_card.runs.size())
			`CHK("first low", f[3] ? ETU : len, u_card.runs[0])
			`CHK("last low", f[2] ? ETU : len, u_card.runs[$])
			if (!f[2]) `CHK("guard high", (10 + f[1:0]) * ETU, u_card.highs[$])
		end
		{pin_force, pin_lvl} <= 2'b11;
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		`CHK("pin direct", 1'b1, sig_out)
		apb(1, 8'h74, 32'h20);
		pin_lvl <= 1'b0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		`CHK("pin delayed", 1'b1, sig_out)
		repeat (6) @(posedge pclk);
		@(negedge pclk);
		`CHK("pin late", 1'b0, sig_out)
		stop_test;
	end
endmodule // cft_frame_tuning_bench
`default_nettype wire
